// File: logic/spp_port.sv
`timescale 1ns/1ns
// top of the programming port: parallel and serial access, update strobe
// assumes all pins asynchronous to clock; staged and active register sets
module spp_port
  import spp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire logic              serial_mode,
  input  wire logic [DATA_W-1:0] parallel_data_bus_in,
  output logic      [DATA_W-1:0] parallel_data_bus_out,
  output logic                   parallel_data_bus_oe,
  input  wire logic [ADDR_W-1:0] register_address_bus,
  input  wire logic              write_strobe_or_serial_clock,
  input  wire logic              read_strobe_or_chip_select,
  output logic                   serial_out_line,
  output logic                   serial_out_line_oe,
  input  wire logic              serial_bidir_line_in,
  output logic                   serial_bidir_line_out,
  output logic                   serial_bidir_line_oe,
  input  wire logic              update_strobe_in,
  output logic                   update_strobe_out,
  output logic                   update_strobe_oe,
  input  wire logic              internal_update,
  output logic [DATA_W*NUM_REGS-1:0] active_regs
);
  // two-stage synchronisers; stage one read only by stage two
  logic [ADDR_W-1:0] a_s1, a_s2;
  logic [DATA_W-1:0] d_s1, d_s2;
  logic [4:0]        p_s1, p_s2;
  logic              wr_prev_q, ud_prev_q, mode_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      a_s1 <= 6'h00;
      a_s2 <= 6'h00;
      d_s1 <= 8'h00;
      d_s2 <= 8'h00;
      p_s1 <= 5'h03;
      p_s2 <= 5'h03;
    end else begin
      a_s1 <= register_address_bus;
      a_s2 <= a_s1;
      d_s1 <= parallel_data_bus_in;
      d_s2 <= d_s1;
      p_s1 <= {serial_mode, serial_bidir_line_in, update_strobe_in,
               read_strobe_or_chip_select, write_strobe_or_serial_clock};
      p_s2 <= p_s1;
    end
  end

  logic wr_s, rd_b_s, ud_s, sdi_s, mode_s;
  assign wr_s   = p_s2[0];
  assign rd_b_s = p_s2[1];
  assign ud_s   = p_s2[2];
  assign sdi_s  = p_s2[3];
  assign mode_s = p_s2[4];

  // staged and active register sets
  logic [DATA_W-1:0] stage_q [NUM_REGS];
  logic [DATA_W-1:0] stage_d [NUM_REGS];
  logic [DATA_W-1:0] act_q   [NUM_REGS];
  logic [DATA_W-1:0] act_d   [NUM_REGS];

  logic ud_out_cfg, ser3w;
  assign ud_out_cfg = stage_q[CTRL_ADDR][CTRL_UD_OUT];
  assign ser3w      = stage_q[CTRL_ADDR][CTRL_SER3W];

  spp_wr_if sbus ();

  logic sdo_w, sdo_oe_w, sdio_oe_w;
  spp_serial u_ser (
    .clock      (clock),
    .rst_b      (rst_b),
    .enable     (mode_s),
    .three_wire (ser3w),
    .resync     (a_s2[2]),
    .cs_b       (rd_b_s),
    .sclk       (wr_s),
    .sdi        (sdi_s),
    .sdo        (sdo_w),
    .sdo_oe     (sdo_oe_w),
    .sdio_oe    (sdio_oe_w),
    .bus        (sbus)
  );

  // parallel write on strobe rising edge
  logic par_wr, ud_rise, do_update;
  assign par_wr    = ~mode_s & wr_s & ~wr_prev_q;
  assign ud_rise   = ud_s & ~ud_prev_q;
  assign do_update = ud_out_cfg ? internal_update : ud_rise;
  assign sbus.rdata = stage_q[sbus.addr];

  always_comb begin
    stage_d = stage_q;
    act_d   = act_q;
    if (par_wr)
      stage_d[a_s2] = d_s2;
    if (sbus.wr_pulse)
      stage_d[sbus.addr] = sbus.wdata;
    if (do_update)
      act_d = stage_q;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        stage_q[i] <= REG_RST;
        act_q[i]   <= REG_RST;
      end
      wr_prev_q <= 1'b0;
      ud_prev_q <= 1'b0;
      mode_q    <= 1'b0;
    end else begin
      stage_q   <= stage_d;
      act_q     <= act_d;
      wr_prev_q <= wr_s;
      ud_prev_q <= ud_s;
      mode_q    <= mode_s;
    end
  end

  // update strobe output pulse; a new update restarts the count
  logic [3:0] ud_cnt_q, ud_cnt_d;
  always_comb begin
    ud_cnt_d = ud_cnt_q;
    if (ud_out_cfg && internal_update)
      ud_cnt_d = 4'(UPD_PULSE_CY);
    else if (ud_cnt_q != 4'h0)
      ud_cnt_d = ud_cnt_q - 4'h1;
  end

  // output pins, all registered
  logic [DATA_W-1:0] pd_out_d;
  logic              pd_oe_d, sdo_d, sdo_oe_d, sdio_d, sdio_oe_d, ud_out_d, ud_oe_d;
  always_comb begin
    pd_oe_d   = ~mode_s & ~rd_b_s;
    pd_out_d  = stage_q[a_s2];
    sdo_d     = sdo_w;
    sdo_oe_d  = mode_s & sdo_oe_w;
    sdio_d    = sdo_w;
    sdio_oe_d = mode_s & sdio_oe_w;
    ud_oe_d   = ud_out_cfg;
    ud_out_d  = ud_out_cfg & (ud_cnt_d != 4'h0);
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ud_cnt_q              <= 4'h0;
      parallel_data_bus_out <= 8'h00;
      parallel_data_bus_oe  <= 1'b0;
      serial_out_line       <= 1'b0;
      serial_out_line_oe    <= 1'b0;
      serial_bidir_line_out <= 1'b0;
      serial_bidir_line_oe  <= 1'b0;
      update_strobe_out     <= 1'b0;
      update_strobe_oe      <= 1'b0;
      active_regs           <= '0;
    end else begin
      ud_cnt_q              <= ud_cnt_d;
      parallel_data_bus_out <= pd_out_d;
      parallel_data_bus_oe  <= pd_oe_d;
      serial_out_line       <= sdo_d;
      serial_out_line_oe    <= sdo_oe_d;
      serial_bidir_line_out <= sdio_d;
      serial_bidir_line_oe  <= sdio_oe_d;
      update_strobe_out     <= ud_out_d;
      update_strobe_oe      <= ud_oe_d;
      for (int i = 0; i < NUM_REGS; i++)
        active_regs[i*DATA_W +: DATA_W] <= act_d[i];
    end
  end

  // helper: count high cycles of the output pulse
  logic [3:0] hi_len_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      hi_len_q <= 4'h0;
    else
      hi_len_q <= update_strobe_out ? hi_len_q + 4'h1 : 4'h0;
  end

  sequence s_upd_req;
    ud_out_cfg && internal_update && !update_strobe_out;
  endsequence

  a_upd_pulse_len: assert property (@(posedge clock) disable iff (!rst_b)
    s_upd_req ##1 !(ud_out_cfg && internal_update) [*8] |=> !update_strobe_out)
    else $error("update pulse not eight clocks");
  a_upd_pulse_max: assert property (@(posedge clock) disable iff (!rst_b)
    hi_len_q <= 4'h8) else $error("update pulse too long");
  a_upd_start: assert property (@(posedge clock) disable iff (!rst_b)
    s_upd_req |=> update_strobe_out) else $error("update pulse did not start");
  a_ud_dir: assert property (@(posedge clock) disable iff (!rst_b)
    update_strobe_oe == $past(ud_out_cfg)) else $error("strobe direction wrong");
  a_ud_in_copy: assert property (@(posedge clock) disable iff (!rst_b)
    !ud_out_cfg && ud_rise |=> act_q[CTRL_ADDR] == $past(stage_q[CTRL_ADDR]))
    else $error("rising update did not copy");
  a_par_write: assert property (@(posedge clock) disable iff (!rst_b)
    par_wr && !sbus.wr_pulse |=> stage_q[$past(a_s2)] == $past(d_s2))
    else $error("parallel write lost");
  a_par_read: assert property (@(posedge clock) disable iff (!rst_b)
    !mode_s && !rd_b_s |=> parallel_data_bus_oe) else $error("read strobe not driving bus");
  a_ser_no_pbus: assert property (@(posedge clock) disable iff (!rst_b)
    mode_s |=> !parallel_data_bus_oe) else $error("parallel bus driven in serial mode");
  a_cs_release: assert property (@(posedge clock) disable iff (!rst_b)
    rd_b_s && mode_s ##1 rd_b_s |=> !serial_out_line_oe && !serial_bidir_line_oe)
    else $error("serial drivers active with chip select high");
  a_lines_exclusive: assert property (@(posedge clock) disable iff (!rst_b)
    !(serial_out_line_oe && serial_bidir_line_oe)) else $error("both serial outputs driven");
endmodule

// File: logic/spp_pkg.sv
// constants and types of the synthesizer programming port
// assumes one 50 MHz clock; all pins arrive asynchronous to it
package spp_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 6;
  localparam int unsigned NUM_REGS     = 64;
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned UPD_PULSE_CY = 8;
  localparam logic [7:0]  REG_RST      = 8'h00;
  // control register that holds the mode bits
  localparam logic [5:0]  CTRL_ADDR    = 6'h1F;
  localparam int unsigned CTRL_UD_OUT  = 0;
  localparam int unsigned CTRL_SER3W   = 1;
  // serial instruction byte: bit 7 read, bits 5..0 address
  localparam int unsigned INS_RD_BIT   = 7;

  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_INSTR,
    SPP_DATA
  } spp_ser_state_t;
endpackage

// File: logic/spp_wr_if.sv
`timescale 1ns/1ns
// write and read path between serial engine and register file
// one clock domain, single-cycle pulses
interface spp_wr_if;
  import spp_pkg::*;
  logic              wr_pulse;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport master (output wr_pulse, output addr, output wdata, input rdata);
  modport slave  (input wr_pulse, input addr, input wdata, output rdata);
endinterface

// File: logic/spp_serial.sv
`timescale 1ns/1ns
// serial engine: instruction byte then one data byte, msb first
// assumes its pin inputs are already synchronised to clock
module spp_serial
  import spp_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic enable,
  input  wire logic three_wire,
  input  wire logic resync,
  input  wire logic cs_b,
  input  wire logic sclk,
  input  wire logic sdi,
  output logic      sdo,
  output logic      sdo_oe,
  output logic      sdio_oe,
  spp_wr_if.master  bus
);
  spp_ser_state_t    st_q, st_d;
  logic [2:0]        cnt_q, cnt_d;
  logic [7:0]        sh_q, sh_d;
  logic              rd_q, rd_d;
  logic [ADDR_W-1:0] a_q, a_d;
  logic              sclk_q, wr_q, wr_d, drv_q, drv_d;
  logic              rise, fall, idle;

  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;
  assign idle = ~enable | resync | cs_b;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    rd_d  = rd_q;
    a_d   = a_q;
    wr_d  = 1'b0;
    drv_d = drv_q;
    if (idle) begin
      st_d  = SPP_IDLE;
      cnt_d = 3'h0;
      drv_d = 1'b0;
    end else begin
      if (st_q == SPP_IDLE)
        st_d = SPP_INSTR;
      if (rise) begin
        sh_d  = {sh_q[6:0], sdi};
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == 3'h7) begin
          case (st_q)
            SPP_INSTR: begin
              rd_d = sh_q[INS_RD_BIT - 1];
              a_d  = {sh_q[4:0], sdi};
              st_d = SPP_DATA;
            end
            SPP_DATA: begin
              wr_d = ~rd_q;
              st_d = SPP_INSTR;
            end
            default: st_d = SPP_IDLE;
          endcase
        end
      end
      if (fall) begin
        drv_d = (st_q == SPP_DATA) & rd_q;
        if (st_q == SPP_DATA && rd_q && cnt_q == 3'h0)
          sh_d = bus.rdata;
        else if (st_q == SPP_DATA && rd_q)
          sh_d = sh_q;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q   <= SPP_IDLE;
      cnt_q  <= 3'h0;
      sh_q   <= 8'h00;
      rd_q   <= 1'b0;
      a_q    <= 6'h00;
      sclk_q <= 1'b0;
      wr_q   <= 1'b0;
      drv_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      rd_q   <= rd_d;
      a_q    <= a_d;
      sclk_q <= sclk;
      wr_q   <= wr_d;
      drv_q  <= drv_d;
    end
  end

  assign bus.wr_pulse = wr_q;
  assign bus.addr     = a_q;
  assign bus.wdata    = sh_q;
  // read data shifts out msb first from the loaded byte
  assign sdo          = (cnt_q == 3'h0 && drv_q) ? bus.rdata[7] : sh_q[7];
  assign sdo_oe       = drv_q & three_wire;
  assign sdio_oe      = drv_q & ~three_wire;

  a_idle_no_drive: assert property (@(posedge clock) disable iff (!rst_b)
    $past(idle) |-> !drv_q) else $error("serial driver active while idle");
  a_resync_to_idle: assert property (@(posedge clock) disable iff (!rst_b)
    resync |=> st_q == SPP_IDLE) else $error("resync did not idle engine");
endmodule

// File: test/spp_host.sv
`timescale 1ns/1ns
// host controller model driving the programming pins
// assumes the bench clock; pins move only right after a rising edge
module spp_host
  import spp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [DATA_W-1:0] pbus,
  input  wire logic              line_3w,
  input  wire logic              line_2w,
  output logic      [ADDR_W-1:0] addr      = 6'h00,
  output logic      [DATA_W-1:0] wdata     = 8'h00,
  output logic                   wr_clk    = 1'b0,
  output logic                   rd_cs_b   = 1'b1,
  output logic                   sdat      = 1'b0,
  output logic                   sdat_oe   = 1'b0,
  output logic                   upd_in    = 1'b0
);
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  // four clocks a phase: the port resolves pins through a two-flop sync
  task automatic par_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr   <= a;
    wdata  <= d;
    hold(4);
    wr_clk <= 1'b1;
    hold(4);
    wr_clk <= 1'b0;
    hold(4);
  endtask

  task automatic par_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    addr    <= a;
    hold(4);
    rd_cs_b <= 1'b0;
    hold(5);
    d = pbus;
    rd_cs_b <= 1'b1;
    hold(5);
  endtask

  task automatic pulse_upd;
    upd_in <= 1'b1;
    hold(4);
    upd_in <= 1'b0;
    hold(6);
  endtask

  // instruction then data, msb first; read bits sampled just before each rise
  task automatic ser_xfer(input logic rd, input logic w3, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rv);
    logic [15:0] frame;
    frame = {rd, 1'b0, a, wd};
    addr    <= 6'h00;
    rd_cs_b <= 1'b0;
    hold(4);
    for (int i = 15; i >= 0; i--) begin
      sdat    <= frame[i];
      sdat_oe <= !(rd && i < 8);
      hold(6);
      if (i < 8) rv[i] = w3 ? line_3w : line_2w;
      wr_clk  <= 1'b1;
      hold(4);
      wr_clk  <= 1'b0;
    end
    hold(4);
    rd_cs_b <= 1'b1;
    hold(4);
  endtask

  // half an instruction, then a resync pulse; chip select stays low
  task automatic ser_abort;
    rd_cs_b <= 1'b0;
    sdat_oe <= 1'b1;
    sdat    <= 1'b1;
    hold(4);
    repeat (4) begin
      wr_clk <= 1'b1;
      hold(4);
      wr_clk <= 1'b0;
      hold(6);
    end
    addr <= 6'h04;
    hold(4);
    addr <= 6'h00;
    hold(4);
  endtask
endmodule

// File: test/spp_port_bench.sv
`timescale 1ns/1ns
// self-checking bench of the programming port with a host model on its pins
// assumes pull-ups on the serial lines when released; the host drives the update strobe whenever the port does not
module spp_port_bench;
  import spp_pkg::*;
  logic                       clock           = 1'b0;
  logic                       rst_b           = 1'b0;
  logic                       serial_mode     = 1'b0;
  logic                       internal_update = 1'b0;
  logic                       quiet           = 1'b0;
  int                         err_total       = 0;
  int                         cmp_count       = 0;
  int                         cyc             = 0;
  logic [ADDR_W-1:0]          h_addr;
  logic [DATA_W-1:0]          h_data, bus_out;
  logic                       h_wr, h_cs_b, h_sdat, h_sdat_oe, h_upd;
  logic                       bus_oe, so, so_oe, sb_out, sb_oe, ud_out, ud_oe;
  logic [DATA_W*NUM_REGS-1:0] active;
  wire  [DATA_W-1:0]          pbus = bus_oe ? bus_out : h_data;
  wire                        line_3w = so_oe ? so : 1'b1;
  wire                        line_2w = sb_oe ? sb_out : (h_sdat_oe ? h_sdat : 1'b1);
  wire                        ud_pin = ud_oe ? ud_out : h_upd;

  always #10 clock = ~clock;

  spp_host u_spp_host (.clock(clock), .pbus(pbus), .line_3w(line_3w), .line_2w(line_2w),
    .addr(h_addr), .wdata(h_data), .wr_clk(h_wr), .rd_cs_b(h_cs_b), .sdat(h_sdat),
    .sdat_oe(h_sdat_oe), .upd_in(h_upd));

  spp_port u_spp_port (.clock(clock), .rst_b(rst_b), .serial_mode(serial_mode),
    .parallel_data_bus_in(pbus), .parallel_data_bus_out(bus_out), .parallel_data_bus_oe(bus_oe),
    .register_address_bus(h_addr), .write_strobe_or_serial_clock(h_wr),
    .read_strobe_or_chip_select(h_cs_b), .serial_out_line(so), .serial_out_line_oe(so_oe),
    .serial_bidir_line_in(line_2w), .serial_bidir_line_out(sb_out), .serial_bidir_line_oe(sb_oe),
    .update_strobe_in(ud_pin), .update_strobe_out(ud_out), .update_strobe_oe(ud_oe),
    .internal_update(internal_update), .active_regs(active));

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // a whole run needs under two thousand cycles
  always @(posedge clock) begin
    cyc++;
    if (quiet && (so_oe || sb_oe)) begin
      err_total++;
      $display("[ERR] serial drivers released expected 0 seen 1");
    end
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic t_par;
    logic [DATA_W-1:0] v;
    u_spp_host.par_wr(6'h05, 8'h5A);
    u_spp_host.par_wr(6'h3F, 8'hC3);
    u_spp_host.par_rd(6'h05, v);
    chk("par read 05", 8'h5A, v);
    u_spp_host.par_rd(6'h3F, v);
    chk("par read 3F", 8'hC3, v);
    chk("par bus oe", 8'h00, {7'h00, bus_oe});
  endtask

  task automatic t_upd_in;
    chk("active 05 staged", 8'h00, active[8*5 +: 8]);
    chk("strobe oe in", 8'h00, {7'h00, ud_oe});
    u_spp_host.pulse_upd();
    chk("active 05", 8'h5A, active[8*5 +: 8]);
    chk("active 3F", 8'hC3, active[8*63 +: 8]);
  endtask

  task automatic t_upd_out;
    logic [DATA_W-1:0] n;
    u_spp_host.par_wr(CTRL_ADDR, 8'h01);
    chk("strobe oe out", 8'h01, {7'h00, ud_oe});
    internal_update <= 1'b1;
    @(posedge clock);
    internal_update <= 1'b0;
    n = 8'h00;
    repeat (14) begin
      @(posedge clock);
      if (ud_out === 1'b1) n++;
    end
    chk("strobe pulse width", 8'h08, n);
    u_spp_host.par_wr(CTRL_ADDR, 8'h02);
  endtask

  task automatic t_ser_3w;
    logic [DATA_W-1:0] v;
    serial_mode <= 1'b1;
    u_spp_host.hold(6);
    u_spp_host.ser_xfer(1'b0, 1'b1, 6'h07, 8'h96, v);
    u_spp_host.ser_xfer(1'b1, 1'b1, 6'h07, 8'h00, v);
    chk("ser3 read 07", 8'h96, v);
    u_spp_host.ser_xfer(1'b1, 1'b1, 6'h05, 8'h00, v);
    chk("ser3 read 05", 8'h5A, v);
  endtask

  task automatic t_ser_2w;
    logic [DATA_W-1:0] v;
    u_spp_host.ser_xfer(1'b0, 1'b1, CTRL_ADDR, 8'h00, v);
    quiet <= 1'b1;
    u_spp_host.par_wr(6'h03, 8'h11);
    quiet <= 1'b0;
    u_spp_host.ser_xfer(1'b1, 1'b0, 6'h03, 8'h00, v);
    chk("ser2 read 03", 8'h00, v);
    u_spp_host.ser_xfer(1'b1, 1'b0, 6'h07, 8'h00, v);
    chk("ser2 read 07", 8'h96, v);
  endtask

  task automatic t_resync;
    logic [DATA_W-1:0] v;
    u_spp_host.ser_abort();
    u_spp_host.ser_xfer(1'b1, 1'b0, 6'h3F, 8'h00, v);
    chk("read after resync", 8'hC3, v);
    u_spp_host.ser_xfer(1'b1, 1'b0, 6'h07, 8'h00, v);
    chk("kept after resync", 8'h96, v);
  endtask

  initial begin
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_par();
    t_upd_in();
    t_upd_out();
    t_ser_3w();
    t_ser_2w();
    t_resync();
    end_of_test();
  end
endmodule
